//--- rtcal_pkg.sv
// rtcal_pkg: register map, field layout and types of the rtc alarm compare block
// assumes: 32-bit axi4-lite slave, one aligned word per 8-bit register
package rtcal_pkg;
	// register byte offsets
	localparam logic [5:0] RTCAL_OFS_CONTROL = 6'h00;
	localparam logic [5:0] RTCAL_OFS_REPEAT = 6'h04;
	localparam logic [5:0] RTCAL_OFS_MONTH = 6'h08;
	localparam logic [5:0] RTCAL_OFS_WEEKDAY = 6'h0c;
	localparam logic [5:0] RTCAL_OFS_DAY = 6'h10;
	localparam logic [5:0] RTCAL_OFS_HOUR = 6'h14;
	localparam logic [5:0] RTCAL_OFS_MINUTE = 6'h18;
	localparam logic [5:0] RTCAL_OFS_SECOND = 6'h1c;
	localparam logic [5:0] RTCAL_OFS_STATUS = 6'h20;
	localparam logic [5:0] RTCAL_OFS_CLEAR = 6'h24;
	localparam logic [5:0] RTCAL_OFS_IRQ_EN = 6'h28;
	// writable-bit masks of the value and control registers
	localparam logic [7:0] RTCAL_MASK_MONTH = 8'h1f;
	localparam logic [7:0] RTCAL_MASK_WEEKDAY = 8'h07;
	localparam logic [7:0] RTCAL_MASK_DAY = 8'h3f;
	localparam logic [7:0] RTCAL_MASK_HOUR = 8'h3f;
	localparam logic [7:0] RTCAL_MASK_MINUTE = 8'h7f;
	localparam logic [7:0] RTCAL_MASK_SECOND = 8'h7f;
	localparam logic [7:0] RTCAL_MASK_CONTROL = 8'hfc;
	// control field positions
	localparam int RTCAL_CTL_ENABLE_BIT = 7;
	localparam int RTCAL_CTL_CHIME_BIT = 6;
	localparam int RTCAL_CTL_MASK_LSB = 2;
	// reset values
	localparam logic [7:0] RTCAL_RST_CONTROL = 8'h00;
	localparam logic [7:0] RTCAL_RST_REPEAT = 8'h00;
	localparam logic [7:0] RTCAL_REPEAT_TOP = 8'hff;
	// status bits: 0 alarm event, 1 auto disable
	localparam int RTCAL_NUM_EVENTS = 2;
	// axi response codes
	localparam logic [1:0] RTCAL_RESP_OKAY = 2'h0;
	localparam logic [1:0] RTCAL_RESP_SLVERR = 2'h2;
	// granularity codes
	typedef enum logic [3:0] {
		RTCAL_G_HALFSEC = 4'h0, RTCAL_G_SEC = 4'h1, RTCAL_G_10SEC = 4'h2,
		RTCAL_G_MIN = 4'h3, RTCAL_G_10MIN = 4'h4, RTCAL_G_HOUR = 4'h5,
		RTCAL_G_DAY = 4'h6, RTCAL_G_WEEK = 4'h7, RTCAL_G_MONTH = 4'h8,
		RTCAL_G_YEAR = 4'h9
	} rtcal_gran_t;
	// calendar time as bcd fields
	typedef struct packed {
		logic [7:0] month;
		logic [7:0] weekday;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
		logic half;
	} rtcal_time_t;
endpackage

//--- rtcal_match.sv
// rtcal_match: compares calendar time with alarm fields under a granularity code
// assumes: both inputs on the same clock, fields already masked to their widths
`timescale 1ns/1ps
module rtcal_match
	import rtcal_pkg::*;
(
	input wire logic [3:0] gran,
	input wire rtcal_time_t now,
	input wire rtcal_time_t alarm,
	output logic hit
);
	// per-field equality, each field but weekday and month cares from some code upward
	always_comb begin
		logic sec_lo, sec_hi, min_lo, min_hi, hr, dy, wd, mo;
		sec_lo = now.second[3:0] == alarm.second[3:0];
		sec_hi = now.second[6:4] == alarm.second[6:4];
		min_lo = now.minute[3:0] == alarm.minute[3:0];
		min_hi = now.minute[6:4] == alarm.minute[6:4];
		hr = now.hour[5:0] == alarm.hour[5:0];
		dy = now.day[5:0] == alarm.day[5:0];
		wd = now.weekday[2:0] == alarm.weekday[2:0];
		mo = now.month[4:0] == alarm.month[4:0];
		hit = 1'b0;
		// reserved codes never match
		if (gran <= RTCAL_G_YEAR) begin
			hit = 1'b1;
			if (gran == RTCAL_G_SEC) hit = !now.half;
			if (gran >= RTCAL_G_10SEC) hit = hit && !now.half && sec_lo;
			if (gran >= RTCAL_G_MIN) hit = hit && sec_hi;
			if (gran >= RTCAL_G_10MIN) hit = hit && min_lo;
			if (gran >= RTCAL_G_HOUR) hit = hit && min_hi;
			if (gran >= RTCAL_G_DAY) hit = hit && hr;
			if (gran == RTCAL_G_WEEK) hit = hit && wd;
			if (gran >= RTCAL_G_MONTH) hit = hit && dy;
			if (gran == RTCAL_G_YEAR) hit = hit && mo;
		end
	end
endmodule // rtcal_match

//--- rtcal_regs.sv
// rtcal_regs: alarm compare registers of the real time calendar, axi4-lite slave
// assumes: calendar fields and its tick come from logic on aclk
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module rtcal_regs
	import rtcal_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire rtcal_time_t cal_time,
	input wire logic cal_tick,
	output logic calendar_interrupt_flag,
	output logic irq
);
	// alarm value storage, deliberately without reset
	logic [7:0] alarm_month_value_reg;
	logic [7:0] alarm_weekday_value_reg;
	logic [7:0] alarm_day_value_reg;
	logic [7:0] alarm_hour_value_reg;
	logic [7:0] alarm_minute_value_reg;
	logic [7:0] alarm_second_value_reg;
	// control and repeat
	logic [7:0] alarm_control_reg;
	logic [7:0] alarm_repeat_count_reg;
	// interrupt status and enable
	logic [RTCAL_NUM_EVENTS-1:0] status_reg;
	logic [RTCAL_NUM_EVENTS-1:0] irq_en_reg;
	logic [RTCAL_NUM_EVENTS-1:0] status_clr; // bits cleared by software this cycle
	logic [RTCAL_NUM_EVENTS-1:0] status_set; // bits raised by hardware this cycle
	// write channel holding
	logic aw_held_reg;
	logic [5:0] aw_addr_reg;
	logic w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_go;
	logic wr_lane0;
	// comparator
	rtcal_time_t alarm_time;
	logic hit;
	logic alarm_event;
	logic alarm_enable;
	logic chime;
	logic auto_off;
	logic [7:0] rd_byte;
	logic rd_err;

	// accept address and data independently, one write in flight
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign wr_go = aw_held_reg && w_held_reg;
	// registers are 8 bits wide, only byte lane 0 carries them
	assign wr_lane0 = wr_go && w_strb_reg[0];

	// helper: is the write to this offset
	function automatic logic wr_hit(input logic [5:0] ofs);
		return wr_lane0 && (aw_addr_reg == ofs);
	endfunction

	// helper: word-aligned byte offset; the low two address bits never select a register
	function automatic logic [5:0] word_ofs(input logic [5:0] a);
		return {a[5:2], 2'h0};
	endfunction

	// address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 6'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= word_ofs(s_axi_awaddr);
		end else if (wr_go) begin
			aw_held_reg <= 1'b0;
		end
	end

	// data capture
	// the whole word and its strobes are kept; only lane 0 reaches a register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_reg <= 1'b0;
		end
	end

	// write response, slverr on unmapped offsets
	// awready and wready stay low while bvalid stands, so one write is in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RTCAL_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_reg > RTCAL_OFS_IRQ_EN) ? RTCAL_RESP_SLVERR
				: RTCAL_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// alarm value fields: no reset branch, masked on write
	always_ff @(posedge aclk) begin
		if (wr_hit(RTCAL_OFS_MONTH))
			alarm_month_value_reg <= w_data_reg[7:0] & RTCAL_MASK_MONTH;
		if (wr_hit(RTCAL_OFS_WEEKDAY))
			alarm_weekday_value_reg <= w_data_reg[7:0] & RTCAL_MASK_WEEKDAY;
		// day tens 5:4, units 3:0
		if (wr_hit(RTCAL_OFS_DAY))
			alarm_day_value_reg <= w_data_reg[7:0] & RTCAL_MASK_DAY;
		// hour tens 5:4, units 3:0
		if (wr_hit(RTCAL_OFS_HOUR))
			alarm_hour_value_reg <= w_data_reg[7:0] & RTCAL_MASK_HOUR;
		// minute tens 6:4, units 3:0
		if (wr_hit(RTCAL_OFS_MINUTE))
			alarm_minute_value_reg <= w_data_reg[7:0] & RTCAL_MASK_MINUTE;
		// second tens 6:4, units 3:0
		if (wr_hit(RTCAL_OFS_SECOND))
			alarm_second_value_reg <= w_data_reg[7:0] & RTCAL_MASK_SECOND;
	end

	// gather stored fields for the comparator
	always_comb begin
		alarm_time.month = alarm_month_value_reg;
		alarm_time.weekday = alarm_weekday_value_reg;
		alarm_time.day = alarm_day_value_reg;
		alarm_time.hour = alarm_hour_value_reg;
		alarm_time.minute = alarm_minute_value_reg;
		alarm_time.second = alarm_second_value_reg;
		alarm_time.half = 1'b0;
	end

	assign alarm_enable = alarm_control_reg[RTCAL_CTL_ENABLE_BIT];
	assign chime = alarm_control_reg[RTCAL_CTL_CHIME_BIT];

	// field compare under the granularity code
	rtcal_match u_match (
		.gran(alarm_control_reg[RTCAL_CTL_MASK_LSB +: 4]),
		.now(cal_time),
		.alarm(alarm_time),
		.hit(hit)
	);

	// cal_tick must be a one-cycle pulse; a longer pulse would count the event once for every cycle it stays high
	// one event per calendar tick at most, so a match lasting many clock cycles fires once per tick
	assign alarm_event = cal_tick && alarm_enable && hit;
	// last shot spent: drop the enable
	assign auto_off = alarm_event && (alarm_repeat_count_reg == 8'h00) && !chime;

	// control word; the auto clear wins over a same-cycle software write of enable
	// bits 1:0 are masked on write, so they always read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_control_reg <= RTCAL_RST_CONTROL;
		end else begin
			if (wr_hit(RTCAL_OFS_CONTROL))
				alarm_control_reg <= w_data_reg[7:0] & RTCAL_MASK_CONTROL;
			if (auto_off)
				alarm_control_reg[RTCAL_CTL_ENABLE_BIT] <= 1'b0;
		end
	end

	// repeat counter: event takes precedence over a software write
	// a write that meets an event is lost; software should reread the count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_repeat_count_reg <= RTCAL_RST_REPEAT;
		end else if (alarm_event) begin
			if (alarm_repeat_count_reg != 8'h00)
				alarm_repeat_count_reg <= alarm_repeat_count_reg - 8'h01;
			else if (chime)
				alarm_repeat_count_reg <= RTCAL_REPEAT_TOP;
		end else if (wr_hit(RTCAL_OFS_REPEAT)) begin
			alarm_repeat_count_reg <= w_data_reg[7:0];
		end
	end

	// sticky status: a set beats a clear in the same cycle
	// a clear that races an event loses, so no alarm is ever lost silently
	always_comb begin
		status_clr = wr_hit(RTCAL_OFS_CLEAR) ? w_data_reg[RTCAL_NUM_EVENTS-1:0] : '0;
		status_set = {auto_off, alarm_event};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			status_reg <= '0;
		else
			status_reg <= (status_reg & ~status_clr) | status_set;
	end

	// interrupt enable
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_en_reg <= '0;
		else if (wr_hit(RTCAL_OFS_IRQ_EN))
			irq_en_reg <= w_data_reg[RTCAL_NUM_EVENTS-1:0];
	end

	// calendar flag mirrors the alarm status bit; irq is the gated level
	// irq is a level: software drops it by clearing status or the enable
	assign calendar_interrupt_flag = status_reg[0];
	assign irq = |(status_reg & irq_en_reg);

	// read decode
	// unmapped words answer slverr and read zero
	always_comb begin
		rd_byte = 8'h00;
		rd_err = 1'b0;
		unique case (word_ofs(s_axi_araddr))
			RTCAL_OFS_CONTROL: rd_byte = alarm_control_reg;
			RTCAL_OFS_REPEAT: rd_byte = alarm_repeat_count_reg;
			RTCAL_OFS_MONTH: rd_byte = alarm_month_value_reg;
			RTCAL_OFS_WEEKDAY: rd_byte = alarm_weekday_value_reg;
			RTCAL_OFS_DAY: rd_byte = alarm_day_value_reg;
			RTCAL_OFS_HOUR: rd_byte = alarm_hour_value_reg;
			RTCAL_OFS_MINUTE: rd_byte = alarm_minute_value_reg;
			RTCAL_OFS_SECOND: rd_byte = alarm_second_value_reg;
			RTCAL_OFS_STATUS: rd_byte = {6'h00, status_reg};
			RTCAL_OFS_IRQ_EN: rd_byte = {6'h00, irq_en_reg};
			RTCAL_OFS_CLEAR: rd_byte = 8'h00; // write-only, reads zero
			default: rd_err = 1'b1;
		endcase
	end

	// read channel: answer one cycle after the address is taken
	// rdata is latched at the handshake, so a later change of a register
	// cannot alter a word that is already on the bus
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RTCAL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= rd_err ? RTCAL_RESP_SLVERR : RTCAL_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// assertions
	// stored field widths
	day_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_hit(RTCAL_OFS_DAY) |=> alarm_day_value_reg == ($past(w_data_reg[7:0]) & 8'h3f))
		else $error("day value not stored as six bits");
	hour_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_hit(RTCAL_OFS_HOUR) |=> alarm_hour_value_reg == ($past(w_data_reg[7:0]) & 8'h3f))
		else $error("hour value not stored as six bits");
	min_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_hit(RTCAL_OFS_MINUTE) |=> alarm_minute_value_reg == ($past(w_data_reg[7:0]) & 8'h7f))
		else $error("minute value not stored as seven bits");
	sec_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_hit(RTCAL_OFS_SECOND) |=> alarm_second_value_reg == ($past(w_data_reg[7:0]) & 8'h7f))
		else $error("second value not stored as seven bits");
	// read-back of the unused day bits
	upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] == 4'h4 |=> s_axi_rdata[7:6] == 2'h0)
		else $error("day upper bits read nonzero");
	// granularity code and repeat counter
	reserved_gran_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_control_reg[5:2] > 4'h9 |-> !alarm_event)
		else $error("alarm event on reserved code");
	repeat_dec_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_event && alarm_repeat_count_reg != 8'h00
		|=> alarm_repeat_count_reg == $past(alarm_repeat_count_reg) - 8'h01)
		else $error("repeat counter did not decrement");
	repeat_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_event && alarm_repeat_count_reg == 8'h00
		|=> alarm_repeat_count_reg == ($past(chime) ? 8'hff : 8'h00))
		else $error("repeat counter wrap wrong");
	auto_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_off |=> !alarm_enable ##1 !alarm_enable || $past(wr_hit(RTCAL_OFS_CONTROL)))
		else $error("enable not cleared after last shot");
	event_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_event |=> calendar_interrupt_flag && status_reg[0])
		else $error("event did not set flag");
	// read-back of the unused upper bits of hour, minute and second
	hour_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] == 4'h5 |=> s_axi_rdata[7:6] == 2'h0)
		else $error("hour upper bits read nonzero");
	minsec_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[5:3] == 3'h3 |=> !s_axi_rdata[7])
		else $error("minute or second bit seven read nonzero");
	// the counter only moves on an event or a software write
	repeat_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!alarm_event && !wr_hit(RTCAL_OFS_REPEAT) |=> $stable(alarm_repeat_count_reg))
		else $error("repeat counter moved without event or write");
	// with chime on, an event never drops the enable
	chime_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_event && chime |=> alarm_enable || $past(wr_hit(RTCAL_OFS_CONTROL)))
		else $error("enable dropped while chime is on");
	// the last shot also marks the auto-disable status bit
	off_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_off |=> status_reg[1])
		else $error("auto-disable status not set");
	// the alarm status bit only rises after an alarm event
	flag_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(status_reg[0]) |-> $past(alarm_event))
		else $error("alarm status set without event");
	// covers of the main scenarios
	chime_wrap_c: cover property (@(posedge aclk) disable iff (!aresetn)
		alarm_event && chime && alarm_repeat_count_reg == 8'h00);
	auto_off_c: cover property (@(posedge aclk) disable iff (!aresetn) auto_off);
	irq_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
	year_c: cover property (@(posedge aclk) disable iff (!aresetn)
		alarm_event && alarm_control_reg[5:2] == 4'h9);
	halfsec_c: cover property (@(posedge aclk) disable iff (!aresetn)
		alarm_event && cal_time.half);
endmodule // rtcal_regs

//--- tb_rtcal_regs.sv
// tb_rtcal_regs: self-checking bench of the alarm compare registers
// assumes: rtcal_pkg compiled first; bready and rready held high all run
`timescale 1ns/1ps
module tb_rtcal_regs
	import rtcal_pkg::*;
;
	logic aclk = 1'b0; // 25 mhz bench clock
	logic aresetn = 1'b0; // synchronous, active low
	logic [5:0] s_axi_awaddr = 6'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b1; // always ready, so no response is ever stalled
	logic [5:0] s_axi_araddr = 6'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b1;
	rtcal_time_t cal_time = '0; // calendar fields seen by the comparator
	rtcal_time_t t0; // reference time that the alarm fields are set to
	rtcal_time_t t;
	logic cal_tick = 1'b0;
	logic calendar_interrupt_flag;
	logic irq;
	int miscompares = 0;
	int checked = 0;
	logic [34:0] exp_q[$]; // notes: {is read, resp, data}
	logic [34:0] note;
	logic [7:0] v;
	// value registers in order month, weekday, day, hour, minute, second
	logic [5:0] ofs_tab [6] = '{RTCAL_OFS_MONTH, RTCAL_OFS_WEEKDAY, RTCAL_OFS_DAY,
		RTCAL_OFS_HOUR, RTCAL_OFS_MINUTE, RTCAL_OFS_SECOND};
	logic [7:0] msk_tab [6] = '{8'h1f, 8'h07, 8'h3f, 8'h3f, 8'h7f, 8'h7f};
	logic [7:0] val_tab [6] = '{8'h06, 8'h03, 8'h15, 8'h12, 8'h45, 8'h30};

	rtcal_regs rtcal_regs_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .cal_time(cal_time), .cal_tick(cal_tick),
		.calendar_interrupt_flag(calendar_interrupt_flag), .irq(irq));

	// free-running clock, 40 ns period
	always #20 aclk = ~aclk;

	task automatic bad(input string m);
		miscompares++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic stop_test();
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one write; address and data offered together, each released when taken
	task automatic wr(input logic [5:0] a, input logic [7:0] d,
		input logic [1:0] r = RTCAL_RESP_OKAY, input logic [3:0] s = 4'h1);
		logic aw_done;
		logic w_done;
		exp_q.push_back({1'b0, r, 32'h0});
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom), d}; // upper lanes random, must be dropped
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
	endtask

	// one read; the monitor compares the answer against the note
	task automatic rd(input logic [5:0] a, input logic [7:0] e,
		input logic [1:0] r = RTCAL_RESP_OKAY);
		exp_q.push_back({1'b1, r, 24'h0, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
	endtask

	// level outputs are compared directly once they have settled
	task automatic pin(input logic got, input logic e, input string m);
		checked++;
		if (got !== e) bad(m);
	endtask

	// one half-second tick with the given calendar time
	task automatic tick(input rtcal_time_t tm);
		cal_time <= tm;
		@(posedge aclk);
		cal_tick <= 1'b1;
		@(posedge aclk);
		cal_tick <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	// arm with one granularity code, tick once, see whether it fired
	task automatic alarm(input logic [3:0] c, input rtcal_time_t tm, input logic hit);
		wr(RTCAL_OFS_CLEAR, 8'h03);
		wr(RTCAL_OFS_REPEAT, 8'h05);
		wr(RTCAL_OFS_CONTROL, {2'b10, c, 2'b00});
		tick(tm);
		rd(RTCAL_OFS_STATUS, {7'h00, hit});
		rd(RTCAL_OFS_REPEAT, hit ? 8'h04 : 8'h05);
		pin(irq, hit, "irq level");
		pin(calendar_interrupt_flag, hit, "event flag");
	endtask

	// monitor: every response takes the oldest note
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			note = exp_q.pop_front();
			checked++;
			if ({1'b0, s_axi_bresp} !== note[34:32]) bad("write response");
		end
		if (s_axi_rvalid && s_axi_rready) begin
			note = exp_q.pop_front();
			checked++;
			if ({1'b1, s_axi_rresp, s_axi_rdata} !== note) bad("read data");
		end
	end

	// watchdog: the whole sequence needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		stop_test();
	end

	initial begin
		void'($urandom(32'h994d));
		t0 = '{8'h06, 8'h03, 8'h15, 8'h12, 8'h45, 8'h30, 1'b0};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		// reset state of control side and interrupt
		rd(RTCAL_OFS_CONTROL, 8'h00);
		rd(RTCAL_OFS_REPEAT, 8'h00);
		rd(RTCAL_OFS_STATUS, 8'h00);
		pin(irq, 1'b0, "irq after reset");
		// field widths: all ones, then a random byte, read back masked
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom);
			wr(ofs_tab[i], 8'hff);
			rd(ofs_tab[i], msk_tab[i]);
			wr(ofs_tab[i], v);
			rd(ofs_tab[i], v & msk_tab[i]);
		end
		wr(RTCAL_OFS_CONTROL, 8'hff); // reserved code 15 cannot fire
		rd(RTCAL_OFS_CONTROL, 8'hfc);
		wr(RTCAL_OFS_CONTROL, 8'h00);
		wr(RTCAL_OFS_REPEAT, 8'hff);
		wr(RTCAL_OFS_REPEAT, 8'h11, RTCAL_RESP_OKAY, 4'he); // lane 0 off: ignored
		rd(RTCAL_OFS_REPEAT, 8'hff);
		// unmapped place and the write-only clear
		wr(6'h2c, 8'h5a, RTCAL_RESP_SLVERR);
		rd(6'h3c, 8'h00, RTCAL_RESP_SLVERR);
		rd(RTCAL_OFS_CLEAR, 8'h00);
		// alarm fields set to the reference time
		for (int i = 0; i < 6; i++) wr(ofs_tab[i], val_tab[i]);
		wr(RTCAL_OFS_IRQ_EN, 8'h03);
		// every code on a full match; reserved ones must stay silent
		for (int c = 0; c < 16; c++) alarm(4'(c), t0, c < 10);
		t = t0;
		t.minute = 8'h46;
		alarm(RTCAL_G_MIN, t, 1'b1);
		alarm(RTCAL_G_10MIN, t, 1'b0);
		t = t0;
		t.half = 1'b1;
		alarm(RTCAL_G_HALFSEC, t, 1'b1);
		alarm(RTCAL_G_SEC, t, 1'b0);
		// countdown without chime: stops at zero, then switches itself off
		wr(RTCAL_OFS_CLEAR, 8'h03);
		wr(RTCAL_OFS_REPEAT, 8'h01);
		wr(RTCAL_OFS_CONTROL, 8'h84);
		tick(t0);
		rd(RTCAL_OFS_REPEAT, 8'h00);
		tick(t0);
		rd(RTCAL_OFS_REPEAT, 8'h00);
		rd(RTCAL_OFS_CONTROL, 8'h04);
		rd(RTCAL_OFS_STATUS, 8'h03);
		wr(RTCAL_OFS_CLEAR, 8'h03);
		tick(t0);
		rd(RTCAL_OFS_STATUS, 8'h00);
		// with chime the counter wraps and the alarm stays armed
		wr(RTCAL_OFS_CONTROL, 8'hc4);
		tick(t0);
		rd(RTCAL_OFS_REPEAT, 8'hff);
		rd(RTCAL_OFS_CONTROL, 8'hc4);
		// interrupt masked, unmasked, then cleared
		wr(RTCAL_OFS_IRQ_EN, 8'h00);
		pin(irq, 1'b0, "irq masked");
		wr(RTCAL_OFS_IRQ_EN, 8'h01);
		pin(irq, 1'b1, "irq unmasked");
		wr(RTCAL_OFS_CLEAR, 8'h01);
		pin(irq, 1'b0, "irq cleared");
		pin(calendar_interrupt_flag, 1'b0, "flag cleared");
		// second reset: control returns to zero, alarm values are kept
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(RTCAL_OFS_CONTROL, 8'h00);
		rd(RTCAL_OFS_SECOND, 8'h30);
		stop_test();
	end
endmodule // tb_rtcal_regs
